// file: verilog/crg_regs.vh
// Behaviour
// - Button-press flag sets on detection, holds until its register is read, then clears.
// - Headset flag is read-only, 1 while headset detected, resets to 0.
// - Coupling bit, reset 0: 0 capless, 1 ac-coupled high-power outputs.
// - Config select A, reset 0: 1 means stereo fully-differential output used.
// - Config select B, reset 0: 1 means stereo pseudo-differential output used.
// - Low three bits of detection register read 000; software writes zeros.
// - Left record mute resets to 1 (muted); writing 0 unmutes.
// - Left gain 7 bits, reset 0, 0.5 dB steps, codes from 1110111 saturate.
// - Right record mute resets to 1 (muted); writing 0 unmutes.
// - Right gain 7 bits, reset 0, same encoding as left, saturating.
// - Upper nibble: left aux mic level, 0000-1000 attenuate, 1111 disconnect, reset 1111.
// - Lower nibble: right aux mic level, same encoding, reset 1111.
// - Headset detection runs only while companion detection enable bit is 1.
`ifndef CRG_REGS_VH
`define CRG_REGS_VH
`define CRG_ADDR_DETECT 7'h0e
`define CRG_ADDR_LGAIN 7'h0f
`define CRG_ADDR_RGAIN 7'h10
`define CRG_ADDR_AUXMIX 7'h11
`define CRG_BIT_COUPLE 7
`define CRG_BIT_CFG_A 6
`define CRG_BIT_BUTTON 5
`define CRG_BIT_HEADSET 4
`define CRG_BIT_CFG_B 3
`define CRG_BIT_MUTE 7
`define CRG_RST_DETECT 8'h00
`define CRG_RST_GAIN 8'h80
`define CRG_RST_AUXMIX 8'hff
`define CRG_GAIN_MAX 7'h77
`define CRG_MIX_MAX 4'h8
`define CRG_MIX_OFF 4'hf
`endif

// file: verilog/crg_mix_decode.v
`timescale 1ns/1ps
`include "crg_regs.vh"
// Decodes one mix nibble into connect and attenuation step
module crg_mix_decode (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [3:0] i_level,
	output reg o_connect,
	output reg [3:0] o_atten_step
);
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_connect <= 1'b0;
			o_atten_step <= 4'h0;
		end else begin
			// Reserved codes are treated as disconnected
			o_connect <= (i_level <= `CRG_MIX_MAX);
			o_atten_step <= (i_level <= `CRG_MIX_MAX) ? i_level : 4'h0;
		end
	end
endmodule // crg_mix_decode

// file: verilog/crg_record_regs.v
`timescale 1ns/1ps
`include "crg_regs.vh"
module crg_record_regs (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [6:0] i_addr,
	input wire i_wr,
	input wire [7:0] i_wdata,
	input wire i_rd,
	input wire i_button_press,
	input wire i_headset_present,
	input wire i_detect_enable,
	output reg [7:0] o_rdata,
	output reg o_rvalid,
	output reg o_couple_ac,
	output reg o_cfg_fully_diff,
	output reg o_cfg_pseudo_diff,
	output reg o_headset_detected,
	output reg o_left_mute,
	output reg [6:0] o_left_gain,
	output reg o_right_mute,
	output reg [6:0] o_right_gain,
	output reg [3:0] o_aux_mic_left_input_level,
	output reg [3:0] o_aux_mic_right_input_level,
	output wire o_aux_mic_left_input_connect,
	output wire [3:0] o_aux_mic_left_input_atten,
	output wire o_aux_mic_right_input_connect,
	output wire [3:0] o_aux_mic_right_input_atten
);

	////////////////////////////////////////////////////////////////////////////
	// Saturate a gain code at the top step
	function [6:0] sat_gain;
		input [6:0] code;
		begin
			sat_gain = (code > `CRG_GAIN_MAX) ? `CRG_GAIN_MAX : code;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Strobe qualified by one register address
	function addr_hit;
		input strobe;
		input [6:0] addr;
		input [6:0] target;
		begin
			addr_hit = strobe && (addr == target);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin inputs pass two flip-flops
	reg [1:0] sync_button;
	reg [1:0] sync_headset;
	reg [1:0] sync_det_en;
	reg button_prev;
	reg button_flag;
	reg headset_flag;
	reg couple;
	reg cfg_a;
	reg cfg_b;
	reg [7:0] lgain;
	reg [7:0] rgain;
	reg [7:0] auxmix;
	reg [7:0] next_rdata;
	wire button_rise;
	wire read_detect;
	wire [7:0] detect_word;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			sync_button <= 2'b00;
			sync_headset <= 2'b00;
			sync_det_en <= 2'b00;
			button_prev <= 1'b0;
		end else begin
			sync_button <= {sync_button[0], i_button_press};
			sync_headset <= {sync_headset[0], i_headset_present};
			sync_det_en <= {sync_det_en[0], i_detect_enable};
			button_prev <= sync_button[1];
		end
	end

	assign button_rise = sync_button[1] & ~button_prev;
	assign read_detect = addr_hit(i_rd, i_addr, `CRG_ADDR_DETECT);

	////////////////////////////////////////////////////////////////////////////
	// Sticky button flag
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			button_flag <= 1'b0;
		end else begin
			// A new press in the read cycle survives the clear
			if (button_rise)
				button_flag <= 1'b1;
			else if (read_detect)
				button_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Headset flag, forced low while detection is off
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			headset_flag <= 1'b0;
		end else begin
			headset_flag <= sync_det_en[1] & sync_headset[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Detect register; read-only bits are not stored
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			couple <= 1'b0;
			cfg_a <= 1'b0;
			cfg_b <= 1'b0;
		end else if (addr_hit(i_wr, i_addr, `CRG_ADDR_DETECT)) begin
			couple <= i_wdata[`CRG_BIT_COUPLE];
			cfg_a <= i_wdata[`CRG_BIT_CFG_A];
			cfg_b <= i_wdata[`CRG_BIT_CFG_B];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Left record gain register
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			lgain <= `CRG_RST_GAIN;
		end else if (addr_hit(i_wr, i_addr, `CRG_ADDR_LGAIN)) begin
			lgain <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Right record gain register
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			rgain <= `CRG_RST_GAIN;
		end else if (addr_hit(i_wr, i_addr, `CRG_ADDR_RGAIN)) begin
			rgain <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Aux mic mix level register
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			auxmix <= `CRG_RST_AUXMIX;
		end else if (addr_hit(i_wr, i_addr, `CRG_ADDR_AUXMIX)) begin
			auxmix <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path: data one cycle after the read strobe
	assign detect_word = {couple, cfg_a, button_flag, headset_flag, cfg_b, 3'b000};

	always @* begin
		case (i_addr)
			`CRG_ADDR_DETECT: next_rdata = detect_word;
			`CRG_ADDR_LGAIN: next_rdata = lgain;
			`CRG_ADDR_RGAIN: next_rdata = rgain;
			`CRG_ADDR_AUXMIX: next_rdata = auxmix;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_rd)
				o_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Driver configuration and status outputs
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_couple_ac <= 1'b0;
			o_cfg_fully_diff <= 1'b0;
			o_cfg_pseudo_diff <= 1'b0;
			o_headset_detected <= 1'b0;
		end else begin
			o_couple_ac <= couple;
			o_cfg_fully_diff <= cfg_a;
			o_cfg_pseudo_diff <= cfg_b;
			o_headset_detected <= headset_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Left record amplifier outputs
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_left_mute <= 1'b1;
			o_left_gain <= 7'h00;
		end else begin
			o_left_mute <= lgain[`CRG_BIT_MUTE];
			o_left_gain <= sat_gain(lgain[6:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Right record amplifier outputs
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_right_mute <= 1'b1;
			o_right_gain <= 7'h00;
		end else begin
			o_right_mute <= rgain[`CRG_BIT_MUTE];
			o_right_gain <= sat_gain(rgain[6:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Raw mix level outputs
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_aux_mic_left_input_level <= `CRG_MIX_OFF;
			o_aux_mic_right_input_level <= `CRG_MIX_OFF;
		end else begin
			o_aux_mic_left_input_level <= auxmix[7:4];
			o_aux_mic_right_input_level <= auxmix[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mix nibble decoders
	crg_mix_decode u_mix_left (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_level(auxmix[7:4]),
		.o_connect(o_aux_mic_left_input_connect),
		.o_atten_step(o_aux_mic_left_input_atten)
	);

	crg_mix_decode u_mix_right (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_level(auxmix[3:0]),
		.o_connect(o_aux_mic_right_input_connect),
		.o_atten_step(o_aux_mic_right_input_atten)
	);

endmodule // crg_record_regs

// file: tb/crg_host.sv
`timescale 1ns/1ps
module crg_host (
	input wire i_ref_clk,
	input wire [7:0] i_rdata,
	output reg [6:0] o_addr = 7'h00,
	output reg o_wr = 1'b0,
	output reg [7:0] o_wdata = 8'h00,
	output reg o_rd = 1'b0
);
task xfer(input w, input [6:0] a, input [7:0] v, output [7:0] d);
	@(negedge i_ref_clk);
	o_addr = a;
	o_wdata = (a == 7'h0e) ? {v[7:4], v[3] & ~v[6], 3'h0} : v;
	{o_wr, o_rd} = {w, !w};
	@(negedge i_ref_clk);
	{o_wr, o_rd} = 2'h0;
	@(negedge i_ref_clk);
	d = i_rdata;
endtask
endmodule // crg_host

// file: tb/crg_record_regs_chk.sv
`timescale 1ns/1ps
module crg_chk (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [6:0] i_addr,
	input wire i_wr,
	input wire [7:0] i_wdata,
	input wire i_rd,
	input wire i_detect_enable,
	input wire [7:0] o_rdata,
	input wire o_rvalid,
	input wire o_headset_detected,
	input wire o_left_mute,
	input wire [6:0] o_left_gain,
	input wire [3:0] o_aux_mic_left_input_level
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
sequence s_wr2(a);
	$past(i_wr, 2) && $past(i_addr, 2) == a;
endsequence
a_left_mute: assert property (s_wr2(7'h0f) |->
	o_left_mute == $past(i_wdata[7], 2)) else $error("mute");
a_mix_follow: assert property (s_wr2(7'h11) |->
	o_aux_mic_left_input_level == $past(i_wdata[7:4], 2)) else $error("level");
a_rd_pulse: assert property (o_rvalid == $past(i_rd)) else $error("rvalid");
a_low_zero: assert property (i_rd && i_addr == 7'h0e |=> o_rdata[2:0] == 3'h0)
	else $error("low bits");
a_hs_off: assert property (!i_detect_enable [*7] |-> !o_headset_detected)
	else $error("headset");
a_reset_vals: assert property ($fell(i_rst) |-> o_left_mute && o_left_gain == 7'h0)
	else $error("reset");
a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("rdata");
a_ctl_hold: assert property (!i_wr [*3] |-> $stable(o_aux_mic_left_input_level))
	else $error("hold");
endmodule // crg_chk
bind crg_record_regs crg_chk u_crg_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .i_detect_enable(i_detect_enable),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_headset_detected(o_headset_detected),
	.o_left_mute(o_left_mute), .o_left_gain(o_left_gain),
	.o_aux_mic_left_input_level(o_aux_mic_left_input_level));

// file: tb/crg_record_regs_bench.sv
`timescale 1ns/1ps
module crg_record_regs_bench;
reg clk = 0, rst = 1, btn = 0, hs = 0, en = 0;
reg [7:0] d;
reg [23:0] rows [0:4] = '{24'h0f7f7f, 24'h118080, 24'h0e8f88, 24'h0e7040, 24'h125500};
integer i, mismatches = 0, n_checks = 0;
wire [6:0] a, lg, rg;
wire [7:0] wd, q;
wire [3:0] ll, rl, la, ra;
wire w, r, hdet, ca, fa, pb, rm, lc, rc;
always #4 clk = ~clk;
crg_host u_crg_host (.i_ref_clk(clk), .i_rdata(q), .o_addr(a), .o_wr(w), .o_wdata(wd), .o_rd(r));
crg_record_regs u_crg_record_regs (.i_ref_clk(clk), .i_rst(rst), .i_addr(a), .i_wr(w),
	.i_wdata(wd), .i_rd(r), .i_button_press(btn), .i_headset_present(hs), .i_detect_enable(en),
	.o_rdata(q), .o_rvalid(), .o_couple_ac(ca), .o_cfg_fully_diff(fa), .o_cfg_pseudo_diff(pb),
	.o_headset_detected(hdet), .o_left_mute(), .o_left_gain(lg), .o_right_mute(rm),
	.o_right_gain(rg), .o_aux_mic_left_input_level(ll), .o_aux_mic_right_input_level(rl),
	.o_aux_mic_left_input_connect(lc), .o_aux_mic_left_input_atten(la),
	.o_aux_mic_right_input_connect(rc), .o_aux_mic_right_input_atten(ra));
task chk(input [7:0] got, input [7:0] exp);
	n_checks = n_checks + 1;
	if (got !== exp) begin
		mismatches = mismatches + 1;
		$display("[ERR] %0t got %h exp %h", $time, got, exp);
	end
endtask
task wrap_up;
	$display("checks %0d mismatches %0d", n_checks, mismatches);
	if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
initial begin
	#100000;
	mismatches = mismatches + 1;
	wrap_up;
end
initial begin
	repeat (20) @(negedge clk);
	rst = 0;
	for (i = 0; i < 4; i = i + 1) begin
		u_crg_host.xfer(0, 7'h0e + i[6:0], 8'h00, d);
		chk(d, (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'h80);
	end
	chk({ll, rl}, 8'hff);
	chk({lc, rc, rm, rg[4:0]}, 8'h20);
	chk({5'h0, ca, fa, pb}, 8'h00);
	$display("reset test done");
	for (i = 0; i < 5; i = i + 1) begin
		u_crg_host.xfer(1, rows[i][22:16], rows[i][15:8], d);
		u_crg_host.xfer(0, rows[i][22:16], 8'h00, d);
		chk(d, rows[i][7:0]);
	end
	chk({1'b0, lg}, 8'h77);
	chk({5'h0, ca, fa, pb}, 8'h02);
	chk({ll, rl}, 8'h80);
	chk({3'h0, lc, la}, 8'h18);
	chk({3'h0, rc, ra}, 8'h10);
	u_crg_host.xfer(1, 7'h0e, 8'h88, d);
	chk({5'h0, ca, fa, pb}, 8'h05);
	u_crg_host.xfer(1, 7'h10, 8'h7a, d);
	chk({rm, rg}, 8'h77);
	$display("table test done");
	{btn, hs, en} = 3'h7;
	repeat (6) @(negedge clk);
	u_crg_host.xfer(0, 7'h0e, 8'h00, d);
	chk({d[7:1], hdet}, 8'hb9);
	{btn, en} = 2'h0;
	repeat (8) @(negedge clk);
	u_crg_host.xfer(0, 7'h0e, 8'h00, d);
	chk({d[7:1], hdet}, 8'h88);
	$display("detect test done");
	wrap_up;
end
endmodule // crg_record_regs_bench
